// ==== design/hrc_params.svh ====
`ifndef HRC_PARAMS_SVH
`define HRC_PARAMS_SVH

// Widths of the configuration word, the data bus and the internal space base.
`define HRC_DATA_W        32
`define HRC_BASE_W        16
`define HRC_ISB_W         3
`define HRC_PS_W          2

// Field positions inside the configuration word.
`define HRC_ARB_BIT       0
`define HRC_IPFX_BIT      1
`define HRC_MCDIS_BIT     2
`define HRC_PS_LO         3
`define HRC_PS_HI         4
`define HRC_ISB_LO        5
`define HRC_ISB_HI        7

// The base field selects the top bits of the internal space base.
`define HRC_ISB_SHIFT     13

// Internal default configuration and the number of edges sampled.
`define HRC_DEFAULT_WORD  32'h0000_0000
`define HRC_SAMPLE_EDGES  2'h2
`define HRC_CNT_ZERO      2'h0
`define HRC_CNT_ONE       2'h1
`define HRC_WORD_ZERO     32'h0000_0000

`endif

// ==== design/hrc_pkg.sv ====
`default_nettype none
`include "hrc_params.svh"

package hrc_pkg;

    // One-hot sequencing: held in hard reset, or running.
    typedef enum logic [1:0]
    {
        HRC_ST_HOLD = 2'b01,
        HRC_ST_RUN  = 2'b10
    } hrc_state_e;

    // Decoded configuration as it is stored.
    typedef struct packed
    {
        logic                    arb_ext;
        logic                    irq_pfx;
        logic                    gpcm_en;
        logic [`HRC_PS_W-1:0]    port_size;
        logic [`HRC_BASE_W-1:0]  base;
    } hrc_cfg_s;

    // The base that a base field selects; software writes the same form.
    function automatic logic [`HRC_BASE_W-1:0] hrc_isb_to_base(
        input logic [`HRC_ISB_W-1:0] internal_space_base_field);
        hrc_isb_to_base = {internal_space_base_field, {`HRC_ISB_SHIFT{1'b0}}};
    endfunction

    // Splits a configuration word into its fields.
    function automatic hrc_cfg_s hrc_decode(input logic [`HRC_DATA_W-1:0] word);
        hrc_cfg_s c;
        c.arb_ext   = word[`HRC_ARB_BIT];
        c.irq_pfx   = word[`HRC_IPFX_BIT];
        c.gpcm_en   = ~word[`HRC_MCDIS_BIT];
        c.port_size = word[`HRC_PS_HI:`HRC_PS_LO];
        c.base      = hrc_isb_to_base(word[`HRC_ISB_HI:`HRC_ISB_LO]);
        hrc_decode  = c;
    endfunction

endpackage : hrc_pkg

`default_nettype wire

// ==== design/hrc_cfg_if.sv ====
`default_nettype none
`include "hrc_params.svh"

interface hrc_cfg_if
    import hrc_pkg::*;
();
    logic                    load;
    hrc_cfg_s                load_cfg;
    logic                    base_wr;
    logic [`HRC_BASE_W-1:0]  base_wdata;
    hrc_cfg_s                cfg;

    // The sequencer commands; the store holds the result.
    modport ctl   (output load, load_cfg, base_wr, base_wdata, input cfg);
    modport store (input load, load_cfg, base_wr, base_wdata, output cfg);
endinterface : hrc_cfg_if

`default_nettype wire

// ==== design/hrc_cfg_store.sv ====
`default_nettype none
`include "hrc_params.svh"

module hrc_cfg_store
    import hrc_pkg::*;
(
    // Clock and reset.
    input  wire logic  clk_sys_i,
    input  wire logic  nrst_i,
    // Command side.
    hrc_cfg_if.store   cfg_if
);

    // Only a commit or a base write changes the store; a commit wins.
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            cfg_if.cfg <= hrc_decode(`HRC_DEFAULT_WORD);
        else if (cfg_if.load)
            cfg_if.cfg <= cfg_if.load_cfg;
        else if (cfg_if.base_wr)
            cfg_if.cfg.base <= cfg_if.base_wdata;
    end

    // Nothing but a commit or a base write may move the held fields.
    AST_HOLD_FIELDS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!cfg_if.load && !cfg_if.base_wr) |=> $stable(cfg_if.cfg))
        else $error("Held configuration changed without cause.");

    // A base write moves the base alone.
    AST_BASE_ONLY: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (cfg_if.base_wr && !cfg_if.load) |=>
            (cfg_if.cfg.base == $past(cfg_if.base_wdata))
            && (cfg_if.cfg.port_size == $past(cfg_if.cfg.port_size))
            && (cfg_if.cfg.gpcm_en == $past(cfg_if.cfg.gpcm_en)))
        else $error("Base write did not relocate only the base.");

endmodule // hrc_cfg_store

`default_nettype wire

// ==== design/hrc_sampler.sv ====
`default_nettype none
`include "hrc_params.svh"

// How it works
// - Capture on last two edges before release.
// - Select pin picks data bus, else default.
// - Word sets arbitration, prefix, disable, width, base.
// - Disabled controller keeps boot chip select off.
// - Base register write relocates like base field.
module hrc_sampler
    import hrc_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic                    clk_sys_i,
    input  wire logic                    nrst_i,
    // Hard reset line and configuration source.
    input  wire logic                    hard_reset_line_n_i,
    input  wire logic                    reset_config_select_n_i,
    input  wire logic [`HRC_DATA_W-1:0]  data_bus_i,
    // Software write of the internal map base register.
    input  wire logic                    map_base_wr_i,
    input  wire logic [`HRC_BASE_W-1:0]  map_base_wdata_i,
    // Chip-select request from the general-purpose machine.
    input  wire logic                    boot_cs_req_i,
    // Configuration outputs.
    output logic                         config_valid_o,
    output logic                         arb_external_o,
    output logic                         irq_prefix_high_o,
    output logic                         gpcm_enable_o,
    output logic [`HRC_PS_W-1:0]         boot_port_size_o,
    output logic [`HRC_BASE_W-1:0]       internal_base_o,
    output logic                         boot_chip_select_n_o
);

    hrc_cfg_if cfg_if ();

    hrc_state_e               state;
    hrc_state_e               next_state;
    logic [1:0]               edge_cnt;
    logic [`HRC_DATA_W-1:0]   samp_last;
    logic [`HRC_DATA_W-1:0]   samp_prev;
    logic                     sel_last;
    logic                     sel_prev;
    logic                     valid;
    logic                     cs_n;

    // Samples stop being taken on the edge at which the line is seen released.
    wire logic                in_hold     = (state == HRC_ST_HOLD);
    wire logic                reset_held  = ~hard_reset_line_n_i;
    wire logic                commit      = in_hold && hard_reset_line_n_i;
    wire logic                two_edges   = (edge_cnt == `HRC_SAMPLE_EDGES);

    // The bus is used only if the select pin was asserted on both sampled edges.
    wire logic                use_bus     = two_edges && sel_last && sel_prev;
    wire logic [`HRC_DATA_W-1:0] chosen_word =
        use_bus ? samp_last : `HRC_DEFAULT_WORD;
    wire hrc_cfg_s            chosen_cfg  = hrc_decode(chosen_word);

    // Software may move the base only once the configuration stands.
    wire logic                sw_base_wr  = (state == HRC_ST_RUN) && map_base_wr_i;

    // A request is let through only with the machine enabled.
    wire logic                next_cs_n   = ~(boot_cs_req_i && valid
                                              && cfg_if.cfg.gpcm_en);

    // State choice: the hard reset line alone moves between the two states.
    always_comb
    begin
        case (state)
            HRC_ST_HOLD: next_state = hard_reset_line_n_i ? HRC_ST_RUN : HRC_ST_HOLD;
            HRC_ST_RUN:  next_state = reset_held ? HRC_ST_HOLD : HRC_ST_RUN;
            default:     next_state = HRC_ST_HOLD;
        endcase
    end

    // Commands to the store.
    assign cfg_if.load       = commit;
    assign cfg_if.load_cfg   = chosen_cfg;
    assign cfg_if.base_wr    = sw_base_wr;
    assign cfg_if.base_wdata = map_base_wdata_i;

    hrc_cfg_store u_store
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .cfg_if    (cfg_if.store)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            state <= HRC_ST_HOLD;
        else
            state <= next_state;
    end

    // A two-deep history of the bus and select pin; only the last two edges
    // before release count, since the device cannot know which edge is last.
    // Sampling starts on the first edge the line is seen low, before the state
    // has moved to hold, so that a hold of exactly two edges gives two samples.
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            samp_last <= `HRC_WORD_ZERO;
            samp_prev <= `HRC_WORD_ZERO;
            sel_last  <= 1'b0;
            sel_prev  <= 1'b0;
        end
        else if (reset_held)
        begin
            samp_last <= data_bus_i;
            samp_prev <= samp_last;
            sel_last  <= ~reset_config_select_n_i;
            sel_prev  <= sel_last;
        end
    end

    // Counts consecutive low edges up to two; a shorter hold falls back to the
    // default. The commit reads the count on the release edge, before it clears.
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || !reset_held)
            edge_cnt <= `HRC_CNT_ZERO;
        else if (!two_edges)
            edge_cnt <= edge_cnt + `HRC_CNT_ONE;
    end

    // Valid from the commit until the line is asserted again.
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            valid <= 1'b0;
        else if (commit)
            valid <= 1'b1;
        else if (reset_held)
            valid <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            cs_n <= 1'b1;
        else
            cs_n <= next_cs_n;
    end

    // Outputs: each is a flip-flop here or in the store.
    assign config_valid_o       = valid;
    assign arb_external_o       = cfg_if.cfg.arb_ext;
    assign irq_prefix_high_o    = cfg_if.cfg.irq_pfx;
    assign gpcm_enable_o        = cfg_if.cfg.gpcm_en;
    assign boot_port_size_o     = cfg_if.cfg.port_size;
    assign internal_base_o      = cfg_if.cfg.base;
    assign boot_chip_select_n_o = cs_n;

    // The commit takes the word seen on the edge just before release.
    AST_CAPTURE_LAST: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (in_hold && reset_held ##1 commit && use_bus) |->
            (chosen_word == $past(data_bus_i)))
        else $error("Captured word is not the last sampled bus value.");

    // Two edges of select keep the bus; fewer use the default.
    AST_SELECT_BUS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (in_hold && reset_held && !reset_config_select_n_i)[*2] ##1 commit |->
            (chosen_word == samp_last))
        else $error("Asserted select did not pick the data bus.");

    AST_SELECT_DEFAULT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (in_hold && reset_held && reset_config_select_n_i) ##1 commit |->
            (chosen_word == `HRC_DEFAULT_WORD))
        else $error("Negated select did not pick the default.");

    // Every output field follows the committed word one edge later.
    AST_FIELDS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        commit |=> config_valid_o
            && (boot_port_size_o == $past(chosen_word[`HRC_PS_HI:`HRC_PS_LO]))
            && (gpcm_enable_o == !$past(chosen_word[`HRC_MCDIS_BIT]))
            && (arb_external_o == $past(chosen_word[`HRC_ARB_BIT]))
            && (irq_prefix_high_o == $past(chosen_word[`HRC_IPFX_BIT]))
            && (internal_base_o == hrc_isb_to_base(
                   $past(chosen_word[`HRC_ISB_HI:`HRC_ISB_LO]))))
        else $error("Configuration outputs do not match the captured word.");

    // A disabled machine never lets the boot chip select assert.
    AST_CS_OFF: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !gpcm_enable_o |=> boot_chip_select_n_o)
        else $error("Boot chip select asserted with the machine disabled.");

    AST_CS_ON: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (boot_cs_req_i && gpcm_enable_o && config_valid_o) |=> !boot_chip_select_n_o)
        else $error("Enabled request did not assert boot chip select.");

    // A write while running lands on the base output one edge later.
    AST_SW_BASE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == HRC_ST_RUN && map_base_wr_i && !reset_held) |=>
            (internal_base_o == $past(map_base_wdata_i)))
        else $error("Base write did not relocate the internal space.");

    // While running without writes, port size, base, enable and arbitration stand still.
    AST_HOLD_RUN: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == HRC_ST_RUN && !map_base_wr_i) |=>
            $stable(boot_port_size_o) && $stable(internal_base_o)
            && $stable(gpcm_enable_o) && $stable(arb_external_o))
        else $error("Configuration changed while running.");

    // The edge counter never passes two during hold.
    AST_EDGE_SAT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        reset_held[*2] |=> two_edges)
        else $error("Edge counter did not saturate at two.");

endmodule // hrc_sampler

`default_nettype wire

// ==== sim/hrc_board_model.sv ====
`default_nettype none
`include "hrc_params.svh"

// Board logic that holds the device in hard reset and drives its configuration word.
module hrc_board_model
(
    // Clock.
    input  wire logic                   clk_i,
    // Commands from the bench.
    input  wire logic                   start_i,
    input  wire logic                   use_bus_i,
    input  wire logic [7:0]             hold_len_i,
    input  wire logic [`HRC_DATA_W-1:0] word_i,
    // Pins towards the device.
    output logic                        hard_reset_n_o,
    output logic                        sel_n_o,
    output logic [`HRC_DATA_W-1:0]      data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]             left = 8'h0;
    logic                   go;
    logic [`HRC_DATA_W-1:0] junk = 32'h5a5a_0001;

    // Pins move just after the edge; a decoy sits before the last sampled edge and a
    // changing pattern follows release, so a stale or early capture shows up.
    always @(posedge clk_i)
    begin
        go = start_i;
        #1;
        junk = ~junk + 32'h0101_0101;
        if (go)
            left = hold_len_i;
        if (left != 8'h0)
        begin
            hard_reset_n_o = 1'b0;
            sel_n_o        = ~use_bus_i;
            data_o         = (left == 8'h1) ? word_i : ~word_i;
            left           = left - 8'h1;
        end
        else
        begin
            hard_reset_n_o = 1'b1;
            sel_n_o        = 1'b1;
            data_o         = junk;
        end
    end
endmodule // hrc_board_model

`default_nettype wire

// ==== sim/hrc_sampler_test.sv ====
`default_nettype none
`include "hrc_params.svh"

module hrc_sampler_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        line_n, sel_n, map_base_wr_i = 1'b0, boot_cs_req_i = 1'b0;
    logic        start = 1'b0, use_bus = 1'b0, valid, arb, pfx, gpcm, cs_n;
    logic [7:0]  hold_len = 8'h2;
    logic [31:0] word = 32'h0, bus;
    logic [15:0] map_base_wdata_i = 16'h0, base;
    logic [1:0]  psz;
    int          fail_count = 0, comparisons = 0, cycles = 0;

    hrc_board_model u_board (.clk_i(clk_sys_i), .start_i(start), .use_bus_i(use_bus),
        .hold_len_i(hold_len), .word_i(word), .hard_reset_n_o(line_n), .sel_n_o(sel_n),
        .data_o(bus));

    hrc_sampler u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hard_reset_line_n_i(line_n),
        .reset_config_select_n_i(sel_n), .data_bus_i(bus), .map_base_wr_i(map_base_wr_i),
        .map_base_wdata_i(map_base_wdata_i), .boot_cs_req_i(boot_cs_req_i),
        .config_valid_o(valid), .arb_external_o(arb), .irq_prefix_high_o(pfx),
        .gpcm_enable_o(gpcm), .boot_port_size_o(psz), .internal_base_o(base),
        .boot_chip_select_n_o(cs_n));

    // Free-running system clock of 40 ns.
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // The word the device must take: the bus only with select and two sampled edges.
    function automatic logic [31:0] eff_word(logic [31:0] w, logic ub, logic [7:0] h);
        return (ub && h >= 8'h2) ? w : `HRC_DEFAULT_WORD;
    endfunction

    task automatic check_fields(input logic [31:0] e);
        check("arb", 32'(arb), 32'(e[0]));
        check("prefix", 32'(pfx), 32'(e[1]));
        check("gpcm", 32'(gpcm), 32'(!e[2]));
        check("size", 32'(psz), 32'(e[4:3]));
        check("base", 32'(base), 32'({e[7:5], 13'h0}));
    endtask

    // One hard reset sequence, a software write refused during holds of three edges or more, then hold and chip select.
    task automatic run_cfg(input logic [31:0] w, input logic ub, input logic [7:0] h);
        logic [31:0] e;
        e = eff_word(w, ub, h);
        word = w;
        use_bus = ub;
        hold_len = h;
        start = 1'b1;
        @(posedge clk_sys_i);
        #1 start = 1'b0;
        for (int i = 0; i < h; i++)
        begin
            @(posedge clk_sys_i);
            #1 map_base_wr_i = (i == 0 && h >= 8'h3);
            map_base_wdata_i = 16'($urandom);
            if (i == 0) check("valid hold", 32'(valid), 32'h0);
        end
        @(posedge clk_sys_i);
        #1 check("valid", 32'(valid), 32'h1);
        check_fields(e);
        repeat (3) @(posedge clk_sys_i);
        #1 check_fields(e);
        boot_cs_req_i = 1'b1;
        @(posedge clk_sys_i);
        #1 check("cs_n", 32'(cs_n), 32'(e[2]));
        boot_cs_req_i = 1'b0;
        @(posedge clk_sys_i);
        #1 check("cs_n idle", 32'(cs_n), 32'h1);
        $display("test word %h bus %0d hold %0d done", w, ub, h);
    endtask

    // Back-to-back software writes of the internal map base register.
    task automatic base_writes(input logic [15:0] a, input logic [15:0] b);
        map_base_wr_i = 1'b1;
        map_base_wdata_i = a;
        @(posedge clk_sys_i);
        #1 check("base wr", 32'(base), 32'(a));
        map_base_wdata_i = b;
        @(posedge clk_sys_i);
        #1 map_base_wr_i = 1'b0;
        check("base wr2", 32'(base), 32'(b));
        $display("test base writes done");
    endtask

    // Main sequence: reset, corner cases, then random configurations.
    initial
    begin
        void'($urandom(32'hdc739f85));
        repeat (3) @(posedge clk_sys_i);
        #1 nrst_i = 1'b1;
        check("valid rst", 32'(valid), 32'h0);
        check_fields(`HRC_DEFAULT_WORD);
        run_cfg(32'h0000_00e4, 1'b1, 8'h2);
        base_writes(16'hffff, 16'h2000);
        run_cfg(32'hffff_ff1b, 1'b1, 8'h1);
        run_cfg(32'h0000_00ff, 1'b0, 8'h3);
        run_cfg(32'h0000_00fb, 1'b1, 8'h5);
        for (int n = 0; n < 20; n++)
        begin
            run_cfg($urandom, 1'($urandom % 4 != 0), 8'(1 + $urandom % 5));
            base_writes(16'($urandom), 16'($urandom));
        end
        print_verdict();
    end
endmodule // hrc_sampler_test

`default_nettype wire
